// ==== design/bscx_exec.sv ====
`timescale 1ns/10ps
`include "bscx_defines.svh"

module bscx_exec
   import bscx_pkg::*;
(
   // clock, reset, enable
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire logic                      ce,
   // instruction from fetch, same clock
   input  wire logic                      instr_valid,
   input  wire bscx_op_t                  instr_op,
   input  wire logic [`BSCX_REG_AW-1:0]   instr_reg,
   input  wire logic [`BSCX_BIT_W-1:0]    instr_bit,
   // register file read port, combinational data
   output logic      [`BSCX_REG_AW-1:0]   rf_addr,
   input  wire logic [7:0]                rf_rdata,
   // page register input
   input  wire logic [7:0]                table_high_page,
   // architectural state
   output logic      [`BSCX_PC_W-1:0]     pc,
   output logic      [7:0]                accumulator,
   output logic                           zero_flag,
   output logic      [`BSCX_SP_W-1:0]     stack_ptr,
   // stack observation
   output logic      [`BSCX_PC_W-1:0]     stack_top,
   // status to the fetch unit
   output logic                           busy,
   output logic                           discard
);

   // sequencer state
   bscx_state_t                 state_q, state_d;
   // state registers
   logic [`BSCX_PC_W-1:0]       pc_q;
   logic [7:0]                  acc_q;
   logic                        z_q;
   logic [`BSCX_SP_W-1:0]       sp_q;
   logic                        busy_q;
   logic                        discard_q;
   // decoded skip decision
   logic                        tested_bit;
   logic                        skip_now;
   // call handling
   logic                        take;
   logic                        push_en;
   logic [`BSCX_PC_W-1:0]       ret_addr;
   logic [`BSCX_PC_W-1:0]       call_target;

   // returns pc plus one, wrapping within the program space
   function automatic logic [`BSCX_PC_W-1:0] bscx_inc
      (input logic [`BSCX_PC_W-1:0] v);
      bscx_inc = v + `BSCX_PC_STEP;
   endfunction : bscx_inc

   ////////////////////////////////////////////////////////////////////////
   // decode

   // new instruction only accepted in the execute state
   assign take        = ce && instr_valid && (state_q == BSCX_ST_EXEC);
   // register file is only read, never written
   // address stays unregistered so the tested bit is seen this cycle
   assign rf_addr     = instr_reg;
   assign tested_bit  = rf_rdata[instr_bit];
   // skip decision by opcode and polarity of the tested bit
   always_comb
   begin
      skip_now = 1'b0;
      if (instr_op == BSCX_OP_SKIP_CLEAR)
      begin
         skip_now = ~tested_bit;
      end
      else if (instr_op == BSCX_OP_SKIP_SET)
      begin
         skip_now = tested_bit;
      end
   end

   // return address and call target
   assign ret_addr    = bscx_inc(pc_q);
   assign call_target = {table_high_page[`BSCX_PAGE_W-1:0],
                         acc_q};
   // a call is the only op that writes the stack
   assign push_en     = take && (instr_op == BSCX_OP_CALL);

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         BSCX_ST_EXEC:
         begin
            if (take && skip_now)
            begin
               state_d = BSCX_ST_NOP;
            end
            else if (push_en)
            begin
               state_d = BSCX_ST_CALL2;
            end
         end
         // inserted no-op cycle, only advances pc past the skipped word
         BSCX_ST_NOP:   state_d = BSCX_ST_EXEC;
         // second call cycle
         BSCX_ST_CALL2: state_d = BSCX_ST_EXEC;
         // unused code, fall back to execute
         default:       state_d = BSCX_ST_EXEC;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_q <= BSCX_ST_EXEC;
      end
      else if (ce)
      begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // program counter
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pc_q <= `BSCX_PC_RESET;
      end
      else if (push_en)
      begin
         pc_q <= call_target;
      end
      else if (take || (ce && state_q == BSCX_ST_NOP))
      begin
         // skipped slot still advances past the discarded word
         pc_q <= bscx_inc(pc_q);
      end
   end

   // stack pointer advances after the slot write
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sp_q <= `BSCX_SP_RESET;
      end
      else if (push_en)
      begin
         sp_q <= sp_q + `BSCX_SP_STEP;
      end
   end

   // return stack, written at the current pointer
   bscx_stack u_stack
   (
      .clk_sys (clk_sys),
      .ce      (ce),
      .wr_en   (push_en),
      .wr_addr (sp_q),
      .wr_data (ret_addr),
      .rd_addr (sp_q - `BSCX_SP_STEP),
      .rd_data (stack_top)
   );

   ////////////////////////////////////////////////////////////////////////
   // accumulator and zero flag
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         acc_q <= `BSCX_ACC_RESET;
         z_q   <= `BSCX_Z_RESET;
      end
      else if (take && instr_op == BSCX_OP_CLEAR_ACC)
      begin
         acc_q <= `BSCX_ACC_CLEAR;
         z_q   <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status to fetch
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         busy_q    <= 1'b0;
         discard_q <= 1'b0;
      end
      else if (ce)
      begin
         // busy tracks the state the sequencer moves into
         busy_q    <= (state_d != BSCX_ST_EXEC);
         discard_q <= take && skip_now;
      end
   end

   // outputs straight from flops
   assign pc          = pc_q;
   assign accumulator = acc_q;
   assign zero_flag   = z_q;
   assign stack_ptr   = sp_q;
   assign busy        = busy_q;
   assign discard     = discard_q;

endmodule : bscx_exec

// ==== design/bscx_defines.svh ====
`ifndef BSCX_DEFINES_SVH
`define BSCX_DEFINES_SVH

// register address range of the data file
`define BSCX_REG_AW     7
`define BSCX_REG_DEPTH  128
// program counter width and page split
`define BSCX_PC_W       11
`define BSCX_PAGE_HI    10
`define BSCX_PAGE_LO    8
`define BSCX_PAGE_W     3
// return stack geometry
`define BSCX_SP_W       3
`define BSCX_STACK_D    8
// constants used by the logic
`define BSCX_ACC_CLEAR  8'h00
`define BSCX_PC_STEP    11'h001
`define BSCX_SP_STEP    3'h1
`define BSCX_PC_RESET   11'h000
`define BSCX_SP_RESET   3'h0
`define BSCX_ACC_RESET  8'h00
`define BSCX_Z_RESET    1'h0
`define BSCX_BIT_W      3

`endif

// ==== design/bscx_pkg.sv ====
package bscx_pkg;

   // instruction opcodes seen by this decoder
   typedef enum logic [2:0]
   {
      BSCX_OP_NONE,
      BSCX_OP_SKIP_CLEAR,
      BSCX_OP_SKIP_SET,
      BSCX_OP_CALL,
      BSCX_OP_CLEAR_ACC
   } bscx_op_t;

   // sequencer states
   typedef enum logic [1:0]
   {
      BSCX_ST_EXEC,
      BSCX_ST_NOP,
      BSCX_ST_CALL2
   } bscx_state_t;

endpackage : bscx_pkg

// ==== design/bscx_stack.sv ====
`timescale 1ns/10ps
`include "bscx_defines.svh"

// return stack memory with registered read data
module bscx_stack
(
   // clock and control
   input  wire logic                    clk_sys,
   input  wire logic                    ce,
   // write side
   input  wire logic                    wr_en,
   input  wire logic [`BSCX_SP_W-1:0]   wr_addr,
   input  wire logic [`BSCX_PC_W-1:0]   wr_data,
   // read side
   input  wire logic [`BSCX_SP_W-1:0]   rd_addr,
   output logic      [`BSCX_PC_W-1:0]   rd_data
);

   // storage array
   logic [`BSCX_PC_W-1:0] mem_q [`BSCX_STACK_D];

   ////////////////////////////////////////////////////////////////////////
   // write port
   always_ff @(posedge clk_sys)
   begin
      if (ce && wr_en)
      begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // registered read port
   always_ff @(posedge clk_sys)
   begin
      if (ce)
      begin
         rd_data <= mem_q[rd_addr];
      end
   end

endmodule : bscx_stack

// ==== verif/bscx_exec_sva.sv ====
`timescale 1ns/10ps
// port-level checks of the exec block
module bscx_exec_sva
   import bscx_pkg::*;
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // instruction side
   input wire logic        ce,
   input wire logic        instr_valid,
   input wire bscx_op_t    instr_op,
   input wire logic [6:0]  instr_reg,
   input wire logic [2:0]  instr_bit,
   input wire logic [6:0]  rf_addr,
   input wire logic [7:0]  rf_rdata,
   input wire logic [7:0]  table_high_page,
   // state
   input wire logic [10:0] pc,
   input wire logic [7:0]  accumulator,
   input wire logic        zero_flag,
   input wire logic [2:0]  stack_ptr,
   input wire logic [10:0] stack_top,
   input wire logic        busy,
   input wire logic        discard
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // accepted op, tested bit, page bits
   wire logic       tk = ce && instr_valid && !busy;
   wire logic       tb = rf_rdata[instr_bit];
   wire logic [2:0] pg = table_high_page[2:0];
   wire logic       sc = tk && instr_op == BSCX_OP_SKIP_CLEAR;
   wire logic       ss = tk && instr_op == BSCX_OP_SKIP_SET;
   wire logic       cl = tk && instr_op == BSCX_OP_CALL;
   wire logic       ca = tk && instr_op == BSCX_OP_CLEAR_ACC;
   property p_sc; sc && !tb |=> discard && busy; endproperty
   a_sc: assert property (p_sc)
      else $error("skip clear");
   property p_ss; ss && tb |=> discard && busy; endproperty
   a_ss: assert property (p_ss)
      else $error("skip set");
   property p_ns;
      sc && tb || ss && !tb |=> !busy && !discard && pc == $past(pc) + 11'h1;
   endproperty
   a_ns: assert property (p_ns)
      else $error("no skip");
   property p_nop;
      discard && ce |=> !busy && pc == $past(pc) + 11'h1 && $stable(stack_ptr);
   endproperty
   a_nop: assert property (p_nop)
      else $error("nop slot");
   property p_call;
      cl |=> busy && pc == {$past(pg), $past(accumulator)}
         && stack_ptr == $past(stack_ptr) + 3'h1;
   endproperty
   a_call: assert property (p_call)
      else $error("call target");
   property p_ret; cl ##1 ce |=> stack_top == $past(pc, 2) + 11'h1; endproperty
   a_ret: assert property (p_ret)
      else $error("return addr");
   property p_clr; ca |=> accumulator == 8'h00 && zero_flag; endproperty
   a_clr: assert property (p_clr)
      else $error("clear acc");
   property p_z; !ca && !rst |=> $stable(zero_flag); endproperty
   a_z: assert property (p_z)
      else $error("zero flag");
   property p_ra; tk |-> rf_addr == instr_reg; endproperty
   a_ra: assert property (p_ra)
      else $error("tested register address");
   // main scenarios reached
   c_sc: cover property (sc && !tb);
   c_ss: cover property (ss && tb);
   c_cl: cover property (cl);
   c_ca: cover property (ca);
endmodule : bscx_exec_sva

// ==== verif/bscx_exec_bench.sv ====
`timescale 1ns/10ps
// random op stream with a queued scoreboard
module bscx_exec_bench import bscx_pkg::*;;
   // design ports
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        instr_valid = 1'b0;
   bscx_op_t    instr_op = BSCX_OP_NONE;
   logic [6:0]  instr_reg = 7'h00;
   logic [2:0]  instr_bit = 3'h0;
   logic [7:0]  rf_rdata = 8'h00;
   logic [7:0]  table_high_page = 8'h00;
   logic [10:0] pc, stack_top;
   logic [7:0]  accumulator;
   logic [2:0]  stack_ptr;
   logic        zero_flag, busy, discard;
   // expected state and notes
   logic [33:0] q[$], got;
   logic [31:0] r = 32'hb7b0;
   logic [10:0] e_pc = 11'h000, e_top = 11'h000;
   logic [2:0]  e_sp = 3'h0;
   logic        e_z = 1'b0, sk, cal;
   int          n_mismatch = 0, checks = 0;
   event        ev;
   always #2.5 clk_sys = ~clk_sys;
   bscx_exec DUT
   (
      .clk_sys         (clk_sys),
      .rst             (rst),
      .ce              (ce),
      .instr_valid     (instr_valid),
      .instr_op        (instr_op),
      .instr_reg       (instr_reg),
      .instr_bit       (instr_bit),
      .rf_addr         (),
      .rf_rdata        (rf_rdata),
      .table_high_page (table_high_page),
      .pc              (pc),
      .accumulator     (accumulator),
      .zero_flag       (zero_flag),
      .stack_ptr       (stack_ptr),
      .stack_top       (stack_top),
      .busy            (busy),
      .discard         (discard)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   // compare settled state with the oldest note
   always @(ev)
   begin
      @(posedge clk_sys);
      #1;
      got = {pc, stack_ptr, zero_flag, accumulator, stack_top};
      chk(got, q.pop_front());
   end
   // one op from the fields of r, a refused clear in its busy slot
   task automatic run_op(input bscx_op_t op);
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr_op <= op;
      instr_reg <= r[8:2];
      instr_bit <= r[11:9];
      rf_rdata <= r[19:12];
      table_high_page <= r[27:20];
      cal = op == BSCX_OP_CALL;
      sk = op == BSCX_OP_SKIP_CLEAR && !r[12 + r[11:9]]
         || op == BSCX_OP_SKIP_SET && r[12 + r[11:9]];
      e_top = cal ? e_pc + 11'h1 : e_top;
      e_pc = cal ? {r[22:20], 8'h00} : e_pc + (sk ? 11'h2 : 11'h1);
      e_sp = e_sp + cal;
      e_z = e_z | (op == BSCX_OP_CLEAR_ACC);
      @(posedge clk_sys);
      // a clear held into the busy cycle must be ignored
      instr_op <= BSCX_OP_CLEAR_ACC;
      instr_valid <= sk || cal;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      q.push_back({e_pc, e_sp, e_z, 8'h00, e_top});
      -> ev;
   endtask : run_op
   // driver: first op a call, then random ops, freeze, reset
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 40; i++)
      begin
         r = lfsr(r);
         run_op(i == 0 ? BSCX_OP_CALL : bscx_op_t'(r[1:0] + 3'h1));
      end
      $display("random op test done");
      // clock enable low: a presented call must change nothing
      @(posedge clk_sys);
      ce <= 1'b0;
      instr_valid <= 1'b1;
      instr_op <= BSCX_OP_CALL;
      repeat (4) @(posedge clk_sys);
      ce <= 1'b1;
      instr_valid <= 1'b0;
      q.push_back({e_pc, e_sp, e_z, 8'h00, e_top});
      -> ev;
      $display("clock enable test done");
      // reset in mid-run, then a call and a clear from reset state
      @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      e_pc = 11'h000;
      e_sp = 3'h0;
      e_z = 1'b0;
      r = lfsr(r);
      run_op(BSCX_OP_CALL);
      r = lfsr(r);
      run_op(BSCX_OP_CLEAR_ACC);
      repeat (2) @(posedge clk_sys);
      $display("reset test done");
      test_done();
   end
   // hang guard, about three times the expected run
   initial
   begin
      #2000;
      n_mismatch++;
      test_done();
   end
endmodule : bscx_exec_bench
bind bscx_exec bscx_exec_sva SVA
(
   .clk_sys         (clk_sys),
   .rst             (rst),
   .ce              (ce),
   .instr_valid     (instr_valid),
   .instr_op        (instr_op),
   .instr_reg       (instr_reg),
   .instr_bit       (instr_bit),
   .rf_addr         (rf_addr),
   .rf_rdata        (rf_rdata),
   .table_high_page (table_high_page),
   .pc              (pc),
   .accumulator     (accumulator),
   .zero_flag       (zero_flag),
   .stack_ptr       (stack_ptr),
   .stack_top       (stack_top),
   .busy            (busy),
   .discard         (discard)
);
